/* buf_mgr_pkg.sv */
package buf_mgr_pkg;
  localparam logic [15:0] ADDR_TX_SEL = 16'h7F52;
  localparam logic [15:0] ADDR_CMD = 16'h7F53;
  localparam logic [15:0] ADDR_ALLOCATION_DONE_IRQ_RESULT = 16'h7F54;
  localparam logic [15:0] ADDR_PKT_SEL = 16'h7F55;
  localparam logic [15:0] ADDR_FREE_PAGES = 16'h7F56;
  localparam logic [15:0] ADDR_DONE_TX = 16'h7F57;
  localparam logic [15:0] ADDR_RX_QUEUE = 16'h7F58;

  localparam int PAGE_COUNT = 32;
  localparam int PAGE_BYTES = 128;
  localparam int MAX_PAGES = 10;
  localparam int RX_DEPTH = 16;
  localparam int DONE_DEPTH = 16;
  localparam int TX_DEPTH = 5;
  localparam int EP_COUNT = 16;
  localparam logic [5:0] ALL_PAGES_FREE = 6'h20;
  localparam logic [3:0] MAX_PAGE_CODE = 4'h9;

  localparam int EMPTY_BIT = 7;
  localparam int FULL_BIT = 6;
  localparam int FAILED_BIT = 7;
  localparam int REFUSE_BIT = 7;
  localparam int CMD_LSB = 5;

  localparam logic [7:0] ALLOCATION_DONE_IRQ_RESULT_RESET = 8'h00;
  localparam logic [4:0] PKT_SEL_RESET = 5'h00;
  localparam logic [3:0] TX_SEL_RESET = 4'h0;
  localparam logic [7:0] DONE_TX_RESET = 8'h80;

  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_ALLOCATION_DONE_IRQ = 3'h1;
  localparam logic [2:0] CMD_RESET = 3'h2;
  localparam logic [2:0] CMD_RX_REMOVE = 3'h3;
  localparam logic [2:0] CMD_RX_RELEASE = 3'h4;
  localparam logic [2:0] CMD_RELEASE = 3'h5;
  localparam logic [2:0] CMD_ENQUEUE = 3'h6;
  localparam logic [2:0] CMD_TX_RESET = 3'h7;

  typedef enum logic {ST_IDLE, ST_ALLOCATION_DONE_IRQ} allocation_done_irq_state_t;

  typedef struct packed {
    logic allocation_done_irq_req;
    logic [3:0] allocation_done_irq_pages;
    logic release_req;
    logic [4:0] release_pkt;
    logic rx_done;
    logic [4:0] rx_pkt;
    logic rx_hdr_ok;
    logic rx_token_bad;
    logic tx_pop;
    logic [3:0] tx_ep;
    logic tx_done;
    logic [4:0] tx_done_pkt;
  } se_in_t;

  typedef struct packed {
    logic allocation_done_irq_ready;
    logic allocation_done_irq_done;
    logic [4:0] allocation_done_irq_pkt;
    logic nak_rx;
    logic rx_overrun;
    logic [4:0] tx_head;
    logic tx_empty;
  } se_out_t;
endpackage

/* pkt_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module pkt_fifo
  import buf_mgr_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [4:0] data_i,
  input wire logic pop_i,
  output logic [4:0] head_o,
  output logic empty_o,
  output logic full_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [4:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  wire do_push = push_i && !full_o;
  wire do_pop = pop_i && !empty_o;

  assign empty_o = (cnt_q == '0);
  assign full_o = (cnt_q == FULL_CNT);
  // An empty queue reads as zero, so no unwritten entry leaks out as unknown
  assign head_o = empty_o ? 5'h00 : mem_q[rd_q];

  always_ff @(posedge clk_i) begin
    if (do_push && !flush_i) begin
      mem_q[wr_q] <= data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* packet_buffer_manager.sv */
// Summary of operation
// - Command 000 does nothing at all.
// - Allocate reserves one to ten 128-byte pages for one packet.
// - Allocate sets the failed flag at once; it clears on completion.
// - Completed firmware allocation raises the allocation-done interrupt; serial engine allocations do not.
// - Short of pages, allocation waits and resumes whenever pages are released.
// - Command 010 frees all pages, clears interrupt, resets all queues.
// - Command 011 drops the receive queue head, pages kept.
// - Command 100 drops the receive queue head and frees its pages.
// - Command 101 frees every page of the selected packet.
// - Enqueue appends selected packet to selected endpoint; firmware selects first.
// - Transmit endpoint reset empties that queue, pages kept.
// - Codes 110 and 111 act on the 4-bit queue select endpoint.
// - Allocation result shows the packet number in bits 4:0.
// - Packet select holds a 5-bit packet number for the data window.
// - Refuse bit 7 NAKs receive and blocks serial engine allocation.
// - Free page register reports unallocated pages, 0 to 32.
// - Completed transmit packets enter a 16-deep completion FIFO.
// - Completion register: bit 7 empty, bit 6 full.
// - Received packet with written header enters receive number queue.
// - Receive register: bit 7 empty, bit 6 full; full refuses packets.
// - Queueing ignores checksum and PID; firmware checks the header.
// - Corrupted token discards the following payload.
`timescale 1ns/10ps
`default_nettype none
module packet_buffer_manager
  import buf_mgr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] mcu_addr_i,
  input wire logic mcu_wr_i,
  input wire logic mcu_rd_i,
  input wire logic [7:0] mcu_wdata_i,
  output logic [7:0] mcu_rdata_o,
  output logic [4:0] window_pkt_o,
  output logic allocation_done_irq_o,
  output logic [2*EP_COUNT-1:0] tx_queue_flags_o,
  input wire se_in_t se_i,
  output se_out_t se_o
);
  logic [3:0] tx_sel_q;
  logic [4:0] pkt_sel_q;
  logic refuse_q;
  logic failed_q;
  logic [4:0] result_q;
  logic irq_q;
  logic [7:0] rdata_q;
  logic [PAGE_COUNT-1:0] used_q;
  logic [4:0] owner_q [PAGE_COUNT];
  allocation_done_irq_state_t state_q;
  logic for_mcu_q;
  logic first_q;
  logic [3:0] need_q;
  logic [4:0] pkt_q;
  logic se_done_q;
  logic [4:0] se_pkt_q;
  logic overrun_q;

  // Register decode
  wire wr_cmd = mcu_wr_i && (mcu_addr_i == ADDR_CMD);
  wire [2:0] cmd = mcu_wdata_i[7:CMD_LSB];
  wire [3:0] cmd_pages = mcu_wdata_i[3:0];
  wire wr_tx_sel = mcu_wr_i && (mcu_addr_i == ADDR_TX_SEL);
  wire wr_pkt_sel = mcu_wr_i && (mcu_addr_i == ADDR_PKT_SEL);
  wire wr_free = mcu_wr_i && (mcu_addr_i == ADDR_FREE_PAGES);
  wire rd_done = mcu_rd_i && (mcu_addr_i == ADDR_DONE_TX);
  wire cmd_reset = wr_cmd && (cmd == CMD_RESET);
  wire cmd_allocation_done_irq = wr_cmd && (cmd == CMD_ALLOCATION_DONE_IRQ);
  wire cmd_remove = wr_cmd && (cmd == CMD_RX_REMOVE);
  wire cmd_rx_rel = wr_cmd && (cmd == CMD_RX_RELEASE);
  wire cmd_release = wr_cmd && (cmd == CMD_RELEASE);
  wire cmd_enqueue = wr_cmd && (cmd == CMD_ENQUEUE);
  wire cmd_tx_reset = wr_cmd && (cmd == CMD_TX_RESET);

  // Receive number queue
  logic [4:0] rx_head;
  logic rx_empty;
  logic rx_full;
  wire rx_discard = se_i.rx_done && se_i.rx_token_bad;
  wire rx_push = se_i.rx_done && se_i.rx_hdr_ok && !se_i.rx_token_bad;
  wire rx_refused = rx_push && rx_full;
  wire rx_pop = (cmd_remove || cmd_rx_rel) && !rx_empty;

  pkt_fifo #(.DEPTH(RX_DEPTH)) u_rx_queue (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(cmd_reset),
    .push_i(rx_push),
    .data_i(se_i.rx_pkt),
    .pop_i(rx_pop),
    .head_o(rx_head),
    .empty_o(rx_empty),
    .full_o(rx_full)
  );

  // Transmit completion FIFO, popped by reading its data port
  logic [4:0] done_head;
  logic done_empty;
  logic done_full;

  pkt_fifo #(.DEPTH(DONE_DEPTH)) u_done_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(cmd_reset),
    .push_i(se_i.tx_done),
    .data_i(se_i.tx_done_pkt),
    .pop_i(rd_done),
    .head_o(done_head),
    .empty_o(done_empty),
    .full_o(done_full)
  );

  // Per-endpoint transmit queues
  logic [4:0] tx_head [EP_COUNT];
  logic [EP_COUNT-1:0] tx_empty;

  for (genvar e = 0; e < EP_COUNT; e++) begin : g_tx
    wire sel_ep = (tx_sel_q == 4'(e));
    logic full_e;
    pkt_fifo #(.DEPTH(TX_DEPTH)) u_txq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .flush_i(cmd_reset || (cmd_tx_reset && sel_ep)),
      .push_i(cmd_enqueue && sel_ep),
      .data_i(pkt_sel_q),
      .pop_i(se_i.tx_pop && (se_i.tx_ep == 4'(e))),
      .head_o(tx_head[e]),
      .empty_o(tx_empty[e]),
      .full_o(full_e)
    );
    assign tx_queue_flags_o[2*e+1] = tx_empty[e];
    assign tx_queue_flags_o[2*e] = full_e;
  end

  // Page release: three sources may free packets in one cycle
  wire [4:0] cmd_rel_pkt = cmd_rx_rel ? rx_head : pkt_sel_q;
  wire cmd_rel = (cmd_rx_rel && !rx_empty) || cmd_release;
  wire se_rel = se_i.release_req;
  wire drop_rel = rx_discard || rx_refused;
  logic [PAGE_COUNT-1:0] rel_mask;

  for (genvar p = 0; p < PAGE_COUNT; p++) begin : g_rel
    assign rel_mask[p] = used_q[p] &&
      ((cmd_rel && owner_q[p] == cmd_rel_pkt) ||
       (se_rel && owner_q[p] == se_i.release_pkt) ||
       (drop_rel && owner_q[p] == se_i.rx_pkt));
  end

  // Lowest free page and free count
  logic [4:0] free_idx;
  logic have_free;
  logic [5:0] free_cnt;

  always_comb begin
    free_idx = '0;
    have_free = 1'b0;
    free_cnt = '0;
    for (int i = PAGE_COUNT - 1; i >= 0; i--) begin
      if (!used_q[i]) begin
        free_idx = 5'(i);
        have_free = 1'b1;
      end
    end
    for (int i = 0; i < PAGE_COUNT; i++) begin
      free_cnt = free_cnt + 6'(!used_q[i]);
    end
  end

  // Allocation engine: one page per cycle, stalls while no page is free
  wire se_take = (state_q == ST_IDLE) && !cmd_allocation_done_irq && !cmd_reset &&
                 se_i.allocation_done_irq_req && !refuse_q;
  wire grab = (state_q == ST_ALLOCATION_DONE_IRQ) && have_free;
  wire last_page = grab && (need_q == 4'h1);
  wire [4:0] grab_pkt = first_q ? free_idx : pkt_q;
  wire [3:0] req_code = cmd_allocation_done_irq ? cmd_pages : se_i.allocation_done_irq_pages;
  wire [3:0] req_pages = (req_code > MAX_PAGE_CODE) ? 4'(MAX_PAGES) : req_code + 4'h1;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      for_mcu_q <= 1'b0;
      first_q <= 1'b0;
      need_q <= '0;
      pkt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_allocation_done_irq || se_take) begin
            state_q <= ST_ALLOCATION_DONE_IRQ;
            for_mcu_q <= cmd_allocation_done_irq;
            first_q <= 1'b1;
            need_q <= req_pages;
          end
        end
        ST_ALLOCATION_DONE_IRQ: begin
          if (cmd_reset) begin
            state_q <= ST_IDLE;
          end else if (grab) begin
            first_q <= 1'b0;
            pkt_q <= grab_pkt;
            need_q <= need_q - 4'h1;
            if (last_page) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (grab) begin
      owner_q[free_idx] <= grab_pkt;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      used_q <= '0;
    end else if (cmd_reset) begin
      used_q <= '0;
    end else begin
      used_q <= (used_q & ~rel_mask) | ({{(PAGE_COUNT-1){1'b0}}, grab} << free_idx);
    end
  end

  // Result, interrupt and serial engine answers
  wire mcu_finish = last_page && for_mcu_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      failed_q <= ALLOCATION_DONE_IRQ_RESULT_RESET[FAILED_BIT];
      result_q <= ALLOCATION_DONE_IRQ_RESULT_RESET[4:0];
      irq_q <= 1'b0;
      se_done_q <= 1'b0;
      se_pkt_q <= '0;
      overrun_q <= 1'b0;
    end else begin
      se_done_q <= last_page && !for_mcu_q && !cmd_reset;
      overrun_q <= rx_refused;
      if (last_page && !for_mcu_q) begin
        se_pkt_q <= grab_pkt;
      end
      if (cmd_reset) begin
        failed_q <= 1'b0;
        irq_q <= 1'b0;
      end else if (cmd_allocation_done_irq && state_q == ST_IDLE) begin
        failed_q <= 1'b1;
        irq_q <= 1'b0;
      end else if (mcu_finish) begin
        failed_q <= 1'b0;
        result_q <= grab_pkt;
        irq_q <= 1'b1;
      end
    end
  end

  // Firmware-written registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_sel_q <= TX_SEL_RESET;
      pkt_sel_q <= PKT_SEL_RESET;
      refuse_q <= 1'b0;
    end else begin
      if (wr_tx_sel) begin
        tx_sel_q <= mcu_wdata_i[3:0];
      end
      if (wr_pkt_sel) begin
        pkt_sel_q <= mcu_wdata_i[4:0];
      end
      if (wr_free) begin
        refuse_q <= mcu_wdata_i[REFUSE_BIT];
      end
    end
  end

  // Read data is captured before any pop of the same access
  logic [7:0] rd_mux;

  always_comb begin
    case (mcu_addr_i)
      ADDR_TX_SEL: rd_mux = {4'h0, tx_sel_q};
      ADDR_ALLOCATION_DONE_IRQ_RESULT: rd_mux = {failed_q, 2'b00, result_q};
      ADDR_PKT_SEL: rd_mux = {3'b000, pkt_sel_q};
      ADDR_FREE_PAGES: rd_mux = {refuse_q, 1'b0, free_cnt};
      ADDR_DONE_TX: rd_mux = {done_empty, done_full, 1'b0, done_head};
      ADDR_RX_QUEUE: rd_mux = {rx_empty, rx_full, 1'b0, rx_head};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (mcu_rd_i) begin
      rdata_q <= rd_mux;
    end
  end

  assign mcu_rdata_o = rdata_q;
  assign window_pkt_o = pkt_sel_q;
  assign allocation_done_irq_o = irq_q;
  assign se_o.allocation_done_irq_ready = (state_q == ST_IDLE) && !refuse_q && !cmd_allocation_done_irq;
  assign se_o.allocation_done_irq_done = se_done_q;
  assign se_o.allocation_done_irq_pkt = se_pkt_q;
  assign se_o.nak_rx = refuse_q;
  assign se_o.rx_overrun = overrun_q;
  assign se_o.tx_head = tx_head[se_i.tx_ep];
  assign se_o.tx_empty = tx_empty[se_i.tx_ep];

  property p_nop;
    @(posedge clk_i) disable iff (rst_i)
    (wr_cmd && cmd == CMD_NOP && state_q == ST_IDLE && !se_i.release_req
     && !se_i.rx_done && !se_take) |=> $stable(used_q) && $stable(failed_q);
  endproperty
  a_nop: assert property (p_nop) else $error("no_operation changed state");

  property p_fail_set;
    @(posedge clk_i) disable iff (rst_i)
    (cmd_allocation_done_irq && state_q == ST_IDLE) |=> failed_q && state_q == ST_ALLOCATION_DONE_IRQ;
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("failed flag not set");

  property p_done;
    @(posedge clk_i) disable iff (rst_i)
    (mcu_finish && !cmd_reset) |=> !failed_q && irq_q && result_q == $past(grab_pkt);
  endproperty
  a_done: assert property (p_done) else $error("completion not reported");

  property p_one_page;
    @(posedge clk_i) disable iff (rst_i)
    (cmd_allocation_done_irq && state_q == ST_IDLE && cmd_pages == 4'h0 && free_cnt != 6'h00
     && !se_i.rx_done && !se_i.release_req) ##1 (!cmd_reset && !cmd_rel
     && !se_i.release_req && !se_i.rx_done) |=> state_q == ST_IDLE
     && free_cnt == $past(free_cnt, 2) - 6'h01;
  endproperty
  a_one_page: assert property (p_one_page) else $error("single page allocation_done_irq wrong");

  property p_reset;
    @(posedge clk_i) disable iff (rst_i)
    cmd_reset |=> free_cnt == ALL_PAGES_FREE && rx_empty && done_empty && !irq_q;
  endproperty
  a_reset: assert property (p_reset) else $error("reset command incomplete");

  property p_release;
    @(posedge clk_i) disable iff (rst_i)
    (cmd_release && !cmd_reset) |=> (used_q & $past(rel_mask)) == '0;
  endproperty
  a_release: assert property (p_release) else $error("pages not released");

  property p_refuse;
    @(posedge clk_i) disable iff (rst_i)
    refuse_q |-> !se_o.allocation_done_irq_ready && !se_take && se_o.nak_rx;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refuse bit ignored");

  property p_rx_push;
    @(posedge clk_i) disable iff (rst_i)
    (rx_push && !cmd_reset) |=> !rx_empty;
  endproperty
  a_rx_push: assert property (p_rx_push) else $error("rx packet not queued");

  property p_done_empty;
    @(posedge clk_i) disable iff (rst_i)
    (rd_done && done_empty) |=> mcu_rdata_o[EMPTY_BIT] && !mcu_rdata_o[FULL_BIT];
  endproperty
  a_done_empty: assert property (p_done_empty) else $error("empty flag wrong");

  property p_rx_read;
    @(posedge clk_i) disable iff (rst_i)
    (mcu_rd_i && !wr_cmd && !rx_push && !rx_empty) |=> $stable(rx_head) && !rx_empty;
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("read altered rx queue");
endmodule
`default_nettype wire

/* se_model.sv */
`timescale 1ns/10ps
`default_nettype none
module se_model
  import buf_mgr_pkg::*;
(
  input wire logic clk_i,
  output se_in_t se_o,
  input wire se_out_t se_i
);
  logic [3:0] ep_q;
  initial begin
    se_o = '0;
    ep_q = 4'h0;
  end
  // Released data fields except tx_ep are scrambled and qualifiers cleared so stale values never look valid
  function automatic se_in_t scrub(input se_in_t v);
    se_in_t q;
    q = ~v;
    q.allocation_done_irq_req = 1'b0;
    q.release_req = 1'b0;
    q.rx_done = 1'b0;
    q.tx_pop = 1'b0;
    q.tx_done = 1'b0;
    q.tx_ep = ep_q;
    return q;
  endfunction
  task automatic fire(input se_in_t v);
    v.tx_ep = ep_q;
    @(posedge clk_i);
    se_o <= v;
    @(posedge clk_i);
    se_o <= scrub(v);
  endtask
  task automatic sel_ep(input logic [3:0] e);
    ep_q = e;
    @(posedge clk_i);
    se_o.tx_ep <= e;
  endtask
  task automatic rx(input logic [4:0] p, input logic ok, input logic bad);
    se_in_t v;
    v = '0;
    v.rx_done = 1'b1;
    v.rx_pkt = p;
    v.rx_hdr_ok = ok;
    v.rx_token_bad = bad;
    fire(v);
  endtask
  task automatic pop();
    se_in_t v;
    v = '0;
    v.tx_pop = 1'b1;
    fire(v);
  endtask
  task automatic free_pkt(input logic [4:0] p);
    se_in_t v;
    v = '0;
    v.release_req = 1'b1;
    v.release_pkt = p;
    fire(v);
  endtask
  task automatic done(input logic [4:0] p);
    se_in_t v;
    v = '0;
    v.tx_done = 1'b1;
    v.tx_done_pkt = p;
    fire(v);
  endtask
  // Holds one request until taken or 50 cycles pass, then waits up to 50 cycles for its completion
  task automatic allocation_done_irq(input logic [3:0] n, output logic [4:0] pkt);
    se_in_t v;
    v = '0;
    v.allocation_done_irq_req = 1'b1;
    v.allocation_done_irq_pages = n;
    v.tx_ep = ep_q;
    pkt = 5'h00;
    @(posedge clk_i);
    se_o <= v;
    repeat (50) begin
      @(negedge clk_i);
      if (se_i.allocation_done_irq_ready === 1'b1) break;
    end
    @(posedge clk_i);
    se_o <= scrub(v);
    repeat (50) begin
      @(negedge clk_i);
      if (se_i.allocation_done_irq_done === 1'b1) break;
    end
    pkt = se_i.allocation_done_irq_pkt;
  endtask
endmodule
`default_nettype wire

/* packet_buffer_manager_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module packet_buffer_manager_bench;
  import buf_mgr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [4:0] window;
  logic irq;
  logic [2*EP_COUNT-1:0] flags;
  se_in_t se_in;
  se_out_t se_out;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [4:0] pkt;
  logic seen;
  always #25 clk_i = ~clk_i;
  packet_buffer_manager dut_u (.clk_i(clk_i), .rst_i(rst_i), .mcu_addr_i(addr),
    .mcu_wr_i(wr), .mcu_rd_i(rd), .mcu_wdata_i(wdata), .mcu_rdata_o(rdata),
    .window_pkt_o(window), .allocation_done_irq_o(irq), .tx_queue_flags_o(flags),
    .se_i(se_in), .se_o(se_out));
  se_model partner_u (.clk_i(clk_i), .se_o(se_in), .se_i(se_out));
  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [3:0] n);
    wr_reg(ADDR_CMD, {c, 1'b0, n});
  endtask
  task automatic chk_reg(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    chk({24'h0, rdata & m}, {24'h0, e});
  endtask
  task automatic wait_irq();
    repeat (60) begin
      @(negedge clk_i);
      if (irq === 1'b1) break;
    end
    chk({31'h0, irq}, 32'h1);
  endtask
  task automatic t_reset_values();
    chk_reg(ADDR_DONE_TX, DONE_TX_RESET, 8'hFF);
    chk_reg(ADDR_FREE_PAGES, 8'h20, 8'hFF);
    chk_reg(ADDR_RX_QUEUE, 8'h80, 8'hC0);
    chk_reg(ADDR_ALLOCATION_DONE_IRQ_RESULT, 8'h00, 8'hFF);
    chk_reg(16'h7F5F, 8'h00, 8'hFF);
    chk(flags, 32'hAAAAAAAA);
  endtask
  task automatic t_allocation_done_irq();
    cmd(CMD_ALLOCATION_DONE_IRQ, 4'h9);
    chk_reg(ADDR_ALLOCATION_DONE_IRQ_RESULT, 8'h80, 8'h80);
    wait_irq();
    chk_reg(ADDR_ALLOCATION_DONE_IRQ_RESULT, 8'h00, 8'hFF);
    chk_reg(ADDR_FREE_PAGES, 8'h16, 8'hFF);
    cmd(CMD_NOP, 4'h0);
    chk_reg(ADDR_FREE_PAGES, 8'h16, 8'hFF);
    chk({31'h0, irq}, 32'h1);
    wr_reg(ADDR_PKT_SEL, 8'h13);
    @(negedge clk_i);
    chk({27'h0, window}, 32'h13);
    chk_reg(ADDR_PKT_SEL, 8'h13, 8'hFF);
  endtask
  task automatic t_wait_release();
    cmd(CMD_ALLOCATION_DONE_IRQ, 4'h9);
    wait_irq();
    cmd(CMD_ALLOCATION_DONE_IRQ, 4'h9);
    wait_irq();
    chk_reg(ADDR_ALLOCATION_DONE_IRQ_RESULT, 8'h14, 8'hFF);
    cmd(CMD_ALLOCATION_DONE_IRQ, 4'h2);
    repeat (20) @(posedge clk_i);
    chk_reg(ADDR_ALLOCATION_DONE_IRQ_RESULT, 8'h80, 8'h80);
    chk({31'h0, irq}, 32'h0);
    wr_reg(ADDR_PKT_SEL, 8'h00);
    cmd(CMD_RELEASE, 4'h0);
    wait_irq();
    chk_reg(ADDR_ALLOCATION_DONE_IRQ_RESULT, 8'h1E, 8'hFF);
    chk_reg(ADDR_FREE_PAGES, 8'h09, 8'hFF);
  endtask
  task automatic t_queues();
    wr_reg(ADDR_TX_SEL, 8'h03);
    wr_reg(ADDR_PKT_SEL, 8'h07);
    cmd(CMD_ENQUEUE, 4'h0);
    partner_u.sel_ep(4'h3);
    @(negedge clk_i);
    chk({31'h0, se_out.tx_empty}, 32'h0);
    partner_u.pop();
    @(negedge clk_i);
    chk({31'h0, se_out.tx_empty}, 32'h1);
    cmd(CMD_ENQUEUE, 4'h0);
    @(negedge clk_i);
    chk(flags, 32'hAAAAAA2A);
    chk({27'h0, se_out.tx_head}, 32'h7);
    cmd(CMD_TX_RESET, 4'h0);
    @(negedge clk_i);
    chk(flags, 32'hAAAAAAAA);
    chk_reg(ADDR_FREE_PAGES, 8'h09, 8'hFF);
    cmd(CMD_ENQUEUE, 4'h0);
    cmd(CMD_RESET, 4'h0);
    @(negedge clk_i);
    chk(flags, 32'hAAAAAAAA);
    chk({31'h0, irq}, 32'h0);
    chk_reg(ADDR_FREE_PAGES, 8'h20, 8'hFF);
  endtask
  task automatic t_rx();
    partner_u.allocation_done_irq(4'h1, pkt);
    chk({27'h0, pkt}, 32'h0);
    partner_u.rx(pkt, 1'b1, 1'b0);
    chk_reg(ADDR_RX_QUEUE, 8'h00, 8'hFF);
    chk_reg(ADDR_RX_QUEUE, 8'h00, 8'hFF);
    partner_u.rx(5'h04, 1'b0, 1'b0);
    partner_u.rx(5'h05, 1'b1, 1'b1);
    cmd(CMD_RX_REMOVE, 4'h0);
    chk_reg(ADDR_RX_QUEUE, 8'h80, 8'hC0);
    chk_reg(ADDR_FREE_PAGES, 8'h1E, 8'hFF);
    partner_u.rx(pkt, 1'b1, 1'b0);
    cmd(CMD_RX_RELEASE, 4'h0);
    chk_reg(ADDR_FREE_PAGES, 8'h20, 8'hFF);
    chk_reg(ADDR_RX_QUEUE, 8'h80, 8'hC0);
    partner_u.allocation_done_irq(4'h0, pkt);
    chk_reg(ADDR_FREE_PAGES, 8'h1F, 8'hFF);
    partner_u.free_pkt(pkt);
    chk_reg(ADDR_FREE_PAGES, 8'h20, 8'hFF);
  endtask
  task automatic t_refuse();
    wr_reg(ADDR_FREE_PAGES, 8'h80);
    chk_reg(ADDR_FREE_PAGES, 8'hA0, 8'hFF);
    chk({31'h0, se_out.nak_rx}, 32'h1);
    chk({31'h0, se_out.allocation_done_irq_ready}, 32'h0);
    wr_reg(ADDR_FREE_PAGES, 8'h00);
    chk_reg(ADDR_FREE_PAGES, 8'h20, 8'hFF);
  endtask
  task automatic t_done_fifo();
    for (int i = 1; i <= 16; i++) begin
      partner_u.done(5'(i));
    end
    chk_reg(ADDR_DONE_TX, 8'h41, 8'hFF);
    for (int i = 2; i <= 16; i++) begin
      chk_reg(ADDR_DONE_TX, 8'(i), 8'hFF);
    end
    chk_reg(ADDR_DONE_TX, 8'h80, 8'hC0);
  endtask
  task automatic t_rx_full();
    for (int i = 0; i < 16; i++) begin
      partner_u.rx(5'(i), 1'b1, 1'b0);
    end
    chk_reg(ADDR_RX_QUEUE, 8'h40, 8'hFF);
    seen = 1'b0;
    partner_u.rx(5'h10, 1'b1, 1'b0);
    repeat (3) begin
      @(negedge clk_i);
      if (se_out.rx_overrun === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h1);
    cmd(CMD_RESET, 4'h0);
    chk_reg(ADDR_RX_QUEUE, 8'h80, 8'hC0);
    cmd(CMD_ALLOCATION_DONE_IRQ, 4'h0);
    wait_irq();
    chk_reg(ADDR_ALLOCATION_DONE_IRQ_RESULT, 8'h00, 8'hFF);
    chk_reg(ADDR_FREE_PAGES, 8'h1F, 8'hFF);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_allocation_done_irq();
    t_wait_release();
    t_queues();
    t_rx();
    t_refuse();
    t_done_fifo();
    t_rx_full();
    tally_and_finish();
  end
endmodule
`default_nettype wire
